// File: rtl/ctb_pkg.sv
// Constants, field layouts and carrier types of the transmit buffer bank.
package ctb_pkg;

  // ****************************************************************
  // Geometry and register map
  // ****************************************************************
  localparam int         NUM_BUF      = 3;
  localparam int         DATA_BYTES   = 8;
  localparam int         ADDR_W       = 8;
  localparam logic [1:0] BUF_LIMIT    = 2'h3;
  localparam logic [3:0] REG_CON      = 4'h0;
  localparam logic [3:0] REG_SIDH     = 4'h1;
  localparam logic [3:0] REG_SIDL     = 4'h2;
  localparam logic [3:0] REG_EIDH     = 4'h3;
  localparam logic [3:0] REG_EIDL     = 4'h4;
  localparam logic [3:0] REG_DLC      = 4'h5;
  localparam logic [3:0] REG_D0       = 4'h6;
  localparam logic [3:0] REG_LAST     = 4'hD;
  localparam logic [7:0] ADDR_TALLY   = 8'hC0;
  localparam logic [7:0] ADDR_STATUS  = 8'hC4;
  localparam logic [7:0] ADDR_MODE    = 8'hC8;

  // ****************************************************************
  // Field positions and implemented-bit masks
  // ****************************************************************
  localparam int         CON_DONE_BIT = 7;
  localparam int         CON_ABT_BIT  = 6;
  localparam int         CON_LARB_BIT = 5;
  localparam int         CON_FAULT_BIT = 4;
  localparam int         CON_REQ_BIT  = 3;
  localparam int         SIDL_EXT_BIT = 3;
  localparam int         DLC_RTR_BIT  = 6;
  localparam logic [7:0] SIDL_MASK    = 8'hEB;
  localparam logic [7:0] DLC_MASK     = 8'h4F;
  localparam int         STAT_BO_BIT  = 2;
  localparam int         STAT_BP_BIT  = 1;
  localparam int         STAT_WARN_BIT = 0;

  // ****************************************************************
  // Fault tally and modes
  // ****************************************************************
  localparam logic [8:0] WARN_LIMIT    = 9'h05F;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] BUSOFF_LIMIT  = 9'h0FF;
  localparam logic [8:0] TALLY_CAP     = 9'h100;
  localparam logic [8:0] FAULT_STEP    = 9'h008;
  localparam logic [8:0] SUCCESS_STEP  = 9'h001;
  localparam logic [7:0] RECOVERY_RUNS = 8'h80;
  localparam logic [1:0] MODE_LEGACY   = 2'h0;
  localparam logic [1:0] MODE_ENH      = 2'h1;
  localparam logic [1:0] MODE_FIFO     = 2'h2;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {ST_IDLE, ST_OFFER} ctb_eng_e;

  typedef struct packed {
    logic                             done;
    logic                             aborted;
    logic                             lost;
    logic                             fault;
    logic                             req;
    logic                             abort_pend;
    logic [1:0]                       pri;
    logic [7:0]                       sidh;
    logic [7:0]                       sidl;
    logic [7:0]                       eidh;
    logic [7:0]                       eidl;
    logic [7:0]                       dlc;
    logic [DATA_BYTES-1:0][7:0]       data;
  } ctb_buf_s;

  typedef struct packed {
    logic [28:0]                      ident;
    logic                             ext;
    logic                             rtr;
    logic [3:0]                       dlc;
    logic [DATA_BYTES-1:0][7:0]       data;
  } ctb_frame_s;

endpackage : ctb_pkg

// File: rtl/ctb_bank.sv
// Three transmit buffers, send scheduler and fault tally behind AXI4-Lite.
//
// Function
// - Done flag sets when a buffer finishes sending; buffer reloadable.
// - Aborted flag sets when a pending message is aborted, not sent.
// - Lost-arbitration flag sets when the buffer's frame loses arbitration.
// - Send-fault flag sets on a bus error during the buffer's frame.
// - Setting send request clears aborted, lost and fault flags.
// - Send request clears itself after successful transmission.
// - Identifier, length and data writes ignored while request is set.
// - Software clearing a set send request asks for an abort.
// - Two-bit priority: 11 highest, 00 lowest.
// - Priority orders buffers only; identifier sent is unchanged.
// - Ident high byte is standard 10..3 or extended 28..21.
// - Ident low bits 7..5 are standard 2..0 or extended 20..18.
// - Extended select sends 29-bit identifier, else 11-bit only.
// - Extended 17..16 from low byte bits 1..0, then two bytes.
// - Extended bytes unused for standard-format messages.
// - Three buffers, eight data bytes each, sent by priority; on equal priority the highest-numbered buffer goes first.
// - Remote-request bit of frame follows length register bit.
// - Length codes 0..8 mean bytes; 9..15 reserved for software.
// - Unimplemented bits of buffer registers read as zero.
// - Read-only eight-bit fault tally; overflow enters bus-off.
// - Tally clears after 128 runs of 11 recessive bits.
// - Warning above 95, passive above 127, bus-off above 255.
// - Modes 00, 01, 10; done flag clearable only outside legacy.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps

module ctb_bank (
  input  wire logic                 CLK_I,
  input  wire logic                 RST_I,
  input  wire logic [7:0]           S_AXI_AWADDR_I,
  input  wire logic                 S_AXI_AWVALID_I,
  output logic                      S_AXI_AWREADY_O,
  input  wire logic [31:0]          S_AXI_WDATA_I,
  input  wire logic [3:0]           S_AXI_WSTRB_I,
  input  wire logic                 S_AXI_WVALID_I,
  output logic                      S_AXI_WREADY_O,
  output logic [1:0]                S_AXI_BRESP_O,
  output logic                      S_AXI_BVALID_O,
  input  wire logic                 S_AXI_BREADY_I,
  input  wire logic [7:0]           S_AXI_ARADDR_I,
  input  wire logic                 S_AXI_ARVALID_I,
  output logic                      S_AXI_ARREADY_O,
  output logic [31:0]               S_AXI_RDATA_O,
  output logic [1:0]                S_AXI_RRESP_O,
  output logic                      S_AXI_RVALID_O,
  input  wire logic                 S_AXI_RREADY_I,
  output logic                      TX_VALID_O,
  output ctb_pkg::ctb_frame_s       TX_FRAME_O,
  output logic [1:0]                TX_BUF_O,
  input  wire logic                 TX_DONE_I,
  input  wire logic                 TX_LOST_ARB_I,
  input  wire logic                 TX_BUS_ERR_I,
  input  wire logic                 RECESSIVE_RUN_I,
  output logic                      BUS_OFF_O,
  output logic                      TX_PASSIVE_O,
  output logic                      TX_WARNING_O
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ctb_pkg::ctb_buf_s [ctb_pkg::NUM_BUF-1:0] bufs;
    ctb_pkg::ctb_eng_e                         eng;
    logic [1:0]                                cur;
    ctb_pkg::ctb_frame_s                       frame;
    logic [8:0]                                tally;
    logic [7:0]                                runs;
    logic                                      bus_off;
    logic                                      passive;
    logic                                      warning;
    logic [1:0]                                mode;
    logic                                      awready;
    logic                                      awpend;
    logic [7:0]                                awaddr;
    logic                                      wready;
    logic                                      wpend;
    logic [7:0]                                wbyte;
    logic                                      wlane;
    logic                                      bvalid;
    logic [1:0]                                bresp;
    logic                                      arready;
    logic                                      rvalid;
    logic [31:0]                               rdata;
    logic [1:0]                                rresp;
  } ctb_state_s;

  ctb_state_s state_ff;
  ctb_state_s nxt_state;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic buf_hit(input logic [7:0] addr);
    buf_hit = (addr[7:6] != ctb_pkg::BUF_LIMIT) &&
              (addr[5:2] <= ctb_pkg::REG_LAST) && (addr[1:0] == 2'b00);
  endfunction : buf_hit

  function automatic logic glob_hit(input logic [7:0] addr);
    glob_hit = (addr == ctb_pkg::ADDR_TALLY) ||
               (addr == ctb_pkg::ADDR_STATUS) ||
               (addr == ctb_pkg::ADDR_MODE);
  endfunction : glob_hit

  function automatic logic [7:0] buf_read(input ctb_pkg::ctb_buf_s b,
                                          input logic [3:0]        r,
                                          input logic [1:0]        mode);
    logic [7:0] v;
    v = 8'h00;
    if (r == ctb_pkg::REG_CON) begin
      v[ctb_pkg::CON_DONE_BIT]  = (mode != ctb_pkg::MODE_LEGACY) & b.done;
      v[ctb_pkg::CON_ABT_BIT]   = b.aborted;
      v[ctb_pkg::CON_LARB_BIT]  = b.lost;
      v[ctb_pkg::CON_FAULT_BIT] = b.fault;
      v[ctb_pkg::CON_REQ_BIT]   = b.req;
      v[1:0]                    = b.pri;
    end else if (r == ctb_pkg::REG_SIDH) begin
      v = b.sidh;
    end else if (r == ctb_pkg::REG_SIDL) begin
      v = b.sidl & ctb_pkg::SIDL_MASK;
    end else if (r == ctb_pkg::REG_EIDH) begin
      v = b.eidh;
    end else if (r == ctb_pkg::REG_EIDL) begin
      v = b.eidl;
    end else if (r == ctb_pkg::REG_DLC) begin
      v = b.dlc & ctb_pkg::DLC_MASK;
    end else begin
      v = b.data[3'(r - ctb_pkg::REG_D0)];
    end
    buf_read = v;
  endfunction : buf_read

  function automatic ctb_pkg::ctb_frame_s make_frame(
      input ctb_pkg::ctb_buf_s b);
    ctb_pkg::ctb_frame_s f;
    f = '0;
    f.ext = b.sidl[ctb_pkg::SIDL_EXT_BIT];
    if (f.ext) begin
      f.ident = {b.sidh, b.sidl[7:5], b.sidl[1:0], b.eidh, b.eidl};
    end else begin
      f.ident = {18'h0_0000, b.sidh, b.sidl[7:5]};
    end
    f.rtr  = b.dlc[ctb_pkg::DLC_RTR_BIT];
    f.dlc  = b.dlc[3:0];
    f.data = b.data;
    make_frame = f;
  endfunction : make_frame

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic       found;
    logic [1:0] best_pri;
    logic [1:0] best;
    logic [1:0] bi;
    logic [3:0] ri;
    logic [7:0] wb;
    logic       in_flight;
    logic       do_write;
    nxt_state = state_ff;
    found     = 1'b0;
    best_pri  = 2'b00;
    best      = 2'b00;
    bi        = state_ff.awaddr[7:6];
    ri        = state_ff.awaddr[5:2];
    wb        = state_ff.wbyte;
    in_flight = 1'b0;
    do_write  = state_ff.awpend && state_ff.wpend && !state_ff.bvalid;

    // Address and data are taken independently, in either order.
    if (S_AXI_AWVALID_I && state_ff.awready) begin
      nxt_state.awpend = 1'b1;
      nxt_state.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && state_ff.wready) begin
      nxt_state.wpend = 1'b1;
      nxt_state.wbyte = S_AXI_WDATA_I[7:0];
      nxt_state.wlane = S_AXI_WSTRB_I[0];
    end
    if (state_ff.bvalid && S_AXI_BREADY_I) begin
      nxt_state.bvalid = 1'b0;
    end

    if (do_write) begin
      nxt_state.awpend = 1'b0;
      nxt_state.wpend  = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp  = ctb_pkg::RESP_OKAY;
      if (buf_hit(state_ff.awaddr) && state_ff.wlane) begin
        in_flight = (state_ff.eng == ctb_pkg::ST_OFFER) &&
                    (state_ff.cur == bi);
        if (ri == ctb_pkg::REG_CON) begin
          nxt_state.bufs[bi].pri = wb[1:0];
          if ((state_ff.mode != ctb_pkg::MODE_LEGACY) &&
              !wb[ctb_pkg::CON_DONE_BIT]) begin
            nxt_state.bufs[bi].done = 1'b0;
          end
          if (wb[ctb_pkg::CON_REQ_BIT] && !state_ff.bufs[bi].req) begin
            nxt_state.bufs[bi].req        = 1'b1;
            nxt_state.bufs[bi].aborted    = 1'b0;
            nxt_state.bufs[bi].lost       = 1'b0;
            nxt_state.bufs[bi].fault      = 1'b0;
            nxt_state.bufs[bi].abort_pend = 1'b0;
          end else if (!wb[ctb_pkg::CON_REQ_BIT] &&
                       state_ff.bufs[bi].req) begin
            if (in_flight) begin
              nxt_state.bufs[bi].abort_pend = 1'b1;
            end else begin
              nxt_state.bufs[bi].req     = 1'b0;
              nxt_state.bufs[bi].aborted = 1'b1;
            end
          end
        end else if (!state_ff.bufs[bi].req) begin
          unique case (ri)
            ctb_pkg::REG_SIDH: nxt_state.bufs[bi].sidh = wb;
            ctb_pkg::REG_SIDL: nxt_state.bufs[bi].sidl = wb;
            ctb_pkg::REG_EIDH: nxt_state.bufs[bi].eidh = wb;
            ctb_pkg::REG_EIDL: nxt_state.bufs[bi].eidl = wb;
            ctb_pkg::REG_DLC:  nxt_state.bufs[bi].dlc  = wb;
            default: begin
              nxt_state.bufs[bi].data[3'(ri - ctb_pkg::REG_D0)] = wb;
            end
          endcase
        end
      end else if (state_ff.awaddr == ctb_pkg::ADDR_MODE) begin
        if (state_ff.wlane) begin
          if (wb[1:0] != 2'b11) begin
            nxt_state.mode = wb[1:0];
          end
        end
      end else if (!glob_hit(state_ff.awaddr)) begin
        nxt_state.bresp = ctb_pkg::RESP_SLVERR;
      end
    end
    nxt_state.awready = !nxt_state.awpend;
    nxt_state.wready  = !nxt_state.wpend;

    // Read channel: one outstanding read, answered the next cycle.
    if (state_ff.rvalid && S_AXI_RREADY_I) begin
      nxt_state.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && state_ff.arready) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp  = ctb_pkg::RESP_OKAY;
      nxt_state.rdata  = 32'h0000_0000;
      if (buf_hit(S_AXI_ARADDR_I)) begin
        nxt_state.rdata[7:0] = buf_read(
          state_ff.bufs[S_AXI_ARADDR_I[7:6]], S_AXI_ARADDR_I[5:2],
          state_ff.mode);
      end else if (S_AXI_ARADDR_I == ctb_pkg::ADDR_TALLY) begin
        nxt_state.rdata[7:0] = state_ff.tally[8] ? 8'hFF
                                                 : state_ff.tally[7:0];
      end else if (S_AXI_ARADDR_I == ctb_pkg::ADDR_STATUS) begin
        nxt_state.rdata[ctb_pkg::STAT_BO_BIT]   = state_ff.bus_off;
        nxt_state.rdata[ctb_pkg::STAT_BP_BIT]   = state_ff.passive;
        nxt_state.rdata[ctb_pkg::STAT_WARN_BIT] = state_ff.warning;
      end else if (S_AXI_ARADDR_I == ctb_pkg::ADDR_MODE) begin
        nxt_state.rdata[1:0] = state_ff.mode;
      end else begin
        nxt_state.rresp = ctb_pkg::RESP_SLVERR;
      end
    end
    nxt_state.arready = !nxt_state.rvalid;

    // Scheduler and outcome handling.  Hardware sets are applied after
    // the register write so that a set in the same cycle wins.
    unique case (state_ff.eng)
      ctb_pkg::ST_IDLE: begin
        for (int i = 0; i < ctb_pkg::NUM_BUF; i++) begin
          if (state_ff.bufs[i].req && !state_ff.bufs[i].abort_pend &&
              (!found || state_ff.bufs[i].pri >= best_pri)) begin
            found    = 1'b1;
            best_pri = state_ff.bufs[i].pri;
            best     = 2'(i);
          end
        end
        // A frame is only offered while the buffer is still requested
        // after this cycle's write, and never during bus-off.
        if (found && nxt_state.bufs[best].req && !state_ff.bus_off) begin
          nxt_state.eng   = ctb_pkg::ST_OFFER;
          nxt_state.cur   = best;
          nxt_state.frame = make_frame(state_ff.bufs[best]);
        end
      end
      ctb_pkg::ST_OFFER: begin
        bi = state_ff.cur;
        if (TX_DONE_I) begin
          nxt_state.bufs[bi].done       = 1'b1;
          nxt_state.bufs[bi].req        = 1'b0;
          nxt_state.bufs[bi].abort_pend = 1'b0;
          nxt_state.eng                 = ctb_pkg::ST_IDLE;
        end else if (TX_LOST_ARB_I || TX_BUS_ERR_I) begin
          if (TX_LOST_ARB_I) begin
            nxt_state.bufs[bi].lost = 1'b1;
          end
          if (TX_BUS_ERR_I) begin
            nxt_state.bufs[bi].fault = 1'b1;
          end
          if (nxt_state.bufs[bi].abort_pend) begin
            nxt_state.bufs[bi].req        = 1'b0;
            nxt_state.bufs[bi].aborted    = 1'b1;
            nxt_state.bufs[bi].abort_pend = 1'b0;
          end
          nxt_state.eng = ctb_pkg::ST_IDLE;
        end
      end
    endcase

    if (state_ff.eng == ctb_pkg::ST_OFFER && TX_BUS_ERR_I) begin
      if (state_ff.tally > ctb_pkg::TALLY_CAP - ctb_pkg::FAULT_STEP) begin
        nxt_state.tally = ctb_pkg::TALLY_CAP;
      end else begin
        nxt_state.tally = state_ff.tally + ctb_pkg::FAULT_STEP;
      end
    end else if (state_ff.eng == ctb_pkg::ST_OFFER && TX_DONE_I &&
                 state_ff.tally != 9'h000 && !state_ff.bus_off) begin
      nxt_state.tally = state_ff.tally - ctb_pkg::SUCCESS_STEP;
    end
    if (state_ff.bus_off && RECESSIVE_RUN_I) begin
      if (state_ff.runs == ctb_pkg::RECOVERY_RUNS - 8'h01) begin
        nxt_state.runs  = 8'h00;
        nxt_state.tally = 9'h000;
      end else begin
        nxt_state.runs = state_ff.runs + 8'h01;
      end
    end
    nxt_state.bus_off = nxt_state.tally > ctb_pkg::BUSOFF_LIMIT;
    nxt_state.passive = nxt_state.tally > ctb_pkg::PASSIVE_LIMIT;
    nxt_state.warning = nxt_state.tally > ctb_pkg::WARN_LIMIT;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Buffer contents are unknown at power-up in the part this mirrors;
  // they are cleared here so that simulation stays free of X.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff         <= '0;
      state_ff.eng     <= ctb_pkg::ST_IDLE;
      state_ff.mode    <= ctb_pkg::MODE_LEGACY;
      state_ff.awready <= 1'b1;
      state_ff.wready  <= 1'b1;
      state_ff.arready <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign S_AXI_AWREADY_O = state_ff.awready;
  assign S_AXI_WREADY_O  = state_ff.wready;
  assign S_AXI_BVALID_O  = state_ff.bvalid;
  assign S_AXI_BRESP_O   = state_ff.bresp;
  assign S_AXI_ARREADY_O = state_ff.arready;
  assign S_AXI_RVALID_O  = state_ff.rvalid;
  assign S_AXI_RDATA_O   = state_ff.rdata;
  assign S_AXI_RRESP_O   = state_ff.rresp;
  assign TX_VALID_O      = (state_ff.eng == ctb_pkg::ST_OFFER);
  assign TX_FRAME_O      = state_ff.frame;
  assign TX_BUF_O        = state_ff.cur;
  assign BUS_OFF_O       = state_ff.bus_off;
  assign TX_PASSIVE_O    = state_ff.passive;
  assign TX_WARNING_O    = state_ff.warning;

endmodule : ctb_bank

// File: verification/ctb_engine_model.sv
// Behavioural protocol engine and bus seen from the transmit buffer bank.
`timescale 1ns/10ps
module ctb_engine_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       valid_i,
  input  wire logic [1:0] outcome_i,
  input  wire logic [4:0] delay_i,
  input  wire logic       idle_runs_i,
  output logic            done_o,
  output logic            lost_o,
  output logic            err_o,
  output logic            run_o
);
  // ****************************************************************
  // Outcome after a programmable delay, one pulse per offer
  // ****************************************************************
  logic [5:0] cnt_ff;
  logic       hit;
  assign hit = valid_i && (cnt_ff == {1'b0, delay_i});
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 6'h00;
      done_o <= 1'b0;
      lost_o <= 1'b0;
      err_o <= 1'b0;
      run_o <= 1'b0;
    end else begin
      cnt_ff <= valid_i ? cnt_ff + 6'h01 : 6'h00;
      done_o <= hit && (outcome_i == 2'h0);
      lost_o <= hit && (outcome_i == 2'h1);
      err_o <= hit && (outcome_i == 2'h2);
      run_o <= idle_runs_i && !run_o;
    end
  end
endmodule : ctb_engine_model

// File: verification/ctb_bank_assertions.sv
// Port assertions for the transmit buffer bank.
`timescale 1ns/10ps
module ctb_bank_assertions (
  input wire logic                S_AXI_ARVALID_I,
  input wire logic                S_AXI_ARREADY_O,
  input wire logic [31:0]         S_AXI_RDATA_O,
  input wire logic                S_AXI_RVALID_O,
  input wire logic                CLK_I,
  input wire logic                RST_I,
  input wire logic                TX_VALID_O,
  input wire ctb_pkg::ctb_frame_s TX_FRAME_O,
  input wire logic [1:0]          TX_BUF_O,
  input wire logic                TX_DONE_I,
  input wire logic                TX_LOST_ARB_I,
  input wire logic                TX_BUS_ERR_I,
  input wire logic                BUS_OFF_O,
  input wire logic                TX_PASSIVE_O,
  input wire logic                TX_WARNING_O
);
  // ****************************************************************
  // Checks
  // ****************************************************************
  logic ev;
  assign ev = TX_DONE_I | TX_LOST_ARB_I | TX_BUS_ERR_I;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  AST_HOLD: assert property (TX_VALID_O && !ev |=> TX_VALID_O &&
    $stable(TX_FRAME_O) && $stable(TX_BUF_O)) else $error("offer moved");
  AST_DROP: assert property (TX_VALID_O && ev |=> !TX_VALID_O)
    else $error("offer held");
  AST_IDX: assert property (TX_VALID_O |-> TX_BUF_O != 2'h3)
    else $error("bad index");
  AST_STD: assert property (TX_VALID_O && !TX_FRAME_O.ext |->
    TX_FRAME_O.ident[28:11] == 18'h0) else $error("std id wide");
  AST_BO: assert property (BUS_OFF_O |-> TX_PASSIVE_O && TX_WARNING_O)
    else $error("bus-off flags");
  AST_BP: assert property (TX_PASSIVE_O |-> TX_WARNING_O)
    else $error("passive flags");
  AST_SKIP: assert property (BUS_OFF_O && !TX_VALID_O |=> !TX_VALID_O)
    else $error("sent in bus-off");
  AST_RD: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=>
    S_AXI_RVALID_O && S_AXI_RDATA_O[31:8] == 24'h0) else $error("read");
  COV_DONE: cover property (TX_VALID_O && TX_DONE_I);
  COV_ERR: cover property (TX_VALID_O && TX_BUS_ERR_I);
  COV_BO: cover property ($fell(BUS_OFF_O));
endmodule : ctb_bank_assertions
bind ctb_bank ctb_bank_assertions u_chk (.S_AXI_ARVALID_I, .S_AXI_ARREADY_O,
  .S_AXI_RDATA_O, .S_AXI_RVALID_O, .CLK_I, .RST_I, .TX_VALID_O, .TX_FRAME_O,
  .TX_BUF_O, .TX_DONE_I, .TX_LOST_ARB_I, .TX_BUS_ERR_I, .BUS_OFF_O,
  .TX_PASSIVE_O, .TX_WARNING_O);

// File: verification/ctb_bank_bench.sv
// Self-checking bench for the transmit buffer bank.
`timescale 1ns/10ps
module ctb_bank_bench;
  logic clk = 1'b0, rst = 1'b1, wvld = 1'b0, arv = 1'b0, run_en = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] oc = 2'h0, tbuf, bresp, rresp;
  logic [4:0] dly = 5'h03;
  logic awr, wrdy, bv, arr, rv, txv, done, lost, berr, run, bo, bp, bw;
  ctb_pkg::ctb_frame_s fr;
  int err_count = 0, checked = 0, n;
  always #2.5 clk = ~clk;
  ctb_bank uut (.CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(adr),
    .S_AXI_AWVALID_I(wvld), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'h1), .S_AXI_WVALID_I(wvld), .S_AXI_WREADY_O(wrdy),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1),
    .S_AXI_ARADDR_I(adr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(1'b1), .TX_VALID_O(txv), .TX_FRAME_O(fr),
    .TX_BUF_O(tbuf), .TX_DONE_I(done), .TX_LOST_ARB_I(lost),
    .TX_BUS_ERR_I(berr), .RECESSIVE_RUN_I(run), .BUS_OFF_O(bo),
    .TX_PASSIVE_O(bp), .TX_WARNING_O(bw));
  ctb_engine_model u_eng (.clk_i(clk), .rst_i(rst), .valid_i(txv),
    .outcome_i(oc), .delay_i(dly), .idle_runs_i(run_en), .done_o(done),
    .lost_o(lost), .err_o(berr), .run_o(run));
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  function automatic logic [7:0] ad(input logic [1:0] b, input logic [3:0] r);
    return {b, r, 2'b00};
  endfunction : ad
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    adr <= a;
    wd <= {24'h0, d};
    wvld <= 1'b1;
    do @(posedge clk); while (!(awr && wrdy));
    wvld <= 1'b0;
    do @(posedge clk); while (!bv);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    adr <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    chk(rdat, {24'h0, e});
  endtask : rd
  task automatic wt(input logic lv);
    do @(posedge clk); while (txv !== lv);
  endtask : wt
  task automatic print_verdict();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ctb_pkg::ADDR_TALLY, 8'h00);
    rd(ad(2'h0, ctb_pkg::REG_CON), 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(ctb_pkg::ADDR_MODE, 8'(m));
      rd(ctb_pkg::ADDR_MODE, (m == 3) ? 8'h02 : 8'(m));
    end
    wr(ctb_pkg::ADDR_MODE, 8'h01);
    wr(ad(2'h0, ctb_pkg::REG_SIDL), 8'hFF);
    rd(ad(2'h0, ctb_pkg::REG_SIDL), 8'hEB);
    wr(ad(2'h0, ctb_pkg::REG_DLC), 8'hFF);
    rd(ad(2'h0, ctb_pkg::REG_DLC), 8'h4F);
    rd(8'hFC, 8'h00);
    chk(rresp, ctb_pkg::RESP_SLVERR);
    wr(8'hFC, 8'h00);
    chk(bresp, ctb_pkg::RESP_SLVERR);
    wr(ad(2'h0, ctb_pkg::REG_SIDH), 8'h24);
    chk(bresp, ctb_pkg::RESP_OKAY);
    wr(ad(2'h0, ctb_pkg::REG_SIDL), 8'h60);
    wr(ad(2'h0, ctb_pkg::REG_EIDH), 8'h5A);
    wr(ad(2'h0, ctb_pkg::REG_DLC), 8'h48);
    for (int i = 0; i < 8; i++) wr(ad(2'h0, 4'(6 + i)), 8'(8'h10 + i));
    wr(ad(2'h0, ctb_pkg::REG_CON), 8'h0F);
    wt(1'b1);
    chk({3'b0, fr.ident}, 32'h0000_0123);
    chk({fr.ext, fr.rtr, fr.dlc}, 32'h0000_0018);
    for (int i = 0; i < 8; i++) chk(fr.data[i], 8'(8'h10 + i));
    wt(1'b0);
    rd(ad(2'h0, ctb_pkg::REG_CON), 8'h83);
    oc <= 2'h2;
    dly <= 5'h02;
    wr(ad(2'h1, ctb_pkg::REG_SIDH), 8'hA5);
    wr(ad(2'h1, ctb_pkg::REG_SIDL), 8'hA9);
    wr(ad(2'h1, ctb_pkg::REG_EIDH), 8'h3C);
    wr(ad(2'h1, ctb_pkg::REG_EIDL), 8'h96);
    wr(ad(2'h1, ctb_pkg::REG_CON), 8'h08);
    wt(1'b1);
    chk({3'b0, fr.ident}, {3'b0, 21'h14_B53C, 8'h96});
    wr(ad(2'h1, ctb_pkg::REG_SIDH), 8'h00);
    rd(ad(2'h1, ctb_pkg::REG_SIDH), 8'hA5);
    rd(ad(2'h1, ctb_pkg::REG_CON), 8'h18);
    wr(ad(2'h1, ctb_pkg::REG_CON), 8'h00);
    repeat (20) @(posedge clk);
    rd(ad(2'h1, ctb_pkg::REG_CON), 8'h50);
    oc <= 2'h1;
    wr(ad(2'h1, ctb_pkg::REG_CON), 8'h08);
    repeat (20) @(posedge clk);
    rd(ad(2'h1, ctb_pkg::REG_CON), 8'h28);
    oc <= 2'h0;
    repeat (20) @(posedge clk);
    rd(ad(2'h1, ctb_pkg::REG_CON), 8'hA0);
    dly <= 5'h14;
    for (int k = 0; k < 2; k++) begin
      wr(ad(2'h0, ctb_pkg::REG_CON), 8'h08);
      wr(ad(2'h1, ctb_pkg::REG_CON), k ? 8'h0B : 8'h09);
      wr(ad(2'h2, ctb_pkg::REG_CON), k ? 8'h08 : 8'h09);
      wt(1'b0);
      wt(1'b1);
      chk(tbuf, k ? 2'h1 : 2'h2);
      repeat (80) @(posedge clk);
    end
    oc <= 2'h2;
    dly <= 5'h00;
    wr(ad(2'h0, ctb_pkg::REG_CON), 8'h08);
    do @(posedge clk); while (!bo);
    rd(ctb_pkg::ADDR_TALLY, 8'hFF);
    rd(ctb_pkg::ADDR_STATUS, 8'h07);
    chk({bo, bp, bw}, 32'h7);
    oc <= 2'h0;
    run_en <= 1'b1;
    n = 0;
    while (bo) begin
      @(posedge clk);
      n += int'(run);
    end
    chk(n, 128);
    run_en <= 1'b0;
    rd(ctb_pkg::ADDR_TALLY, 8'h00);
    rd(ad(2'h2, ctb_pkg::REG_CON), 8'h80);
    wr(ad(2'h1, ctb_pkg::REG_CON), 8'h03);
    rd(ad(2'h1, ctb_pkg::REG_CON), 8'h03);
    wr(ctb_pkg::ADDR_MODE, 8'h00);
    rd(ad(2'h2, ctb_pkg::REG_CON), 8'h00);
    print_verdict();
  end
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule : ctb_bank_bench
